// *** aegc_pkg.sv ***
// Purpose: Shared constants for the auto exposure and gain register bank
// Assumes: 32-bit quadlets, bit 0 of a quadlet is its most significant bit
// Notes:   Feature index 0 is the brightness target, 1 exposure, 2 gain
//
// Behaviour
// R1 - With auto exposure on, exposure time moves within its limits toward the target brightness.
// R2 - With auto gain on, gain moves within its limits toward the target brightness.
// R3 - A larger target value asks for a brighter image, a smaller one for a darker image.
// R4 - Both loops are proportional plus integral controllers tuned for no overshoot.
// R5 - Bit 0 of each feature register reads as a fixed 1 because the feature exists.
// R6 - Bit 1 chooses the value field (0) or the separate absolute value input (1).
// R7 - Writing 1 to bit 5 of the exposure register starts a one-shot that reads 1 until it clears itself.
// R8 - A one-shot request to the exposure register is ignored while it is in auto mode.
// R9 - Bit 5 of the gain and target registers starts a one-shot and reads 1 while busy.
// R10 - Bit 6 switches the feature on or off and reads back its state.
// R11 - Bit 7 selects manual (0) or auto (1) and reads back the active mode.
// R12 - Writes to the value field are dropped while the feature is in auto or off.
// R13 - Software must not trust the value field where readout is not supported.
// R14 - The target used by the loops is held within 50 to 205 grey levels.
// R15 - The target steers gain only with auto gain active or a gain one-shot busy, and gain stays in its limits.
// R16 - Each register is one quadlet whose reserved bits read zero and ignore writes.
// R17 - In auto mode the setting is updated once per frame from that frame's mean brightness.
package aegc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_TGT  = 32'hf0f00804;
  localparam logic [31:0] ADDR_EXP  = 32'hf0f0081c;
  localparam logic [31:0] ADDR_GAIN = 32'hf0f00820;

  // ----------------------------------------------------------------
  // Field positions (quadlet bit n sits at vector bit 31-n)
  // ----------------------------------------------------------------
  localparam int B_PRES = 31;
  localparam int B_ABS  = 30;
  localparam int B_ONE  = 26;
  localparam int B_ON   = 25;
  localparam int B_AUTO = 24;
  localparam int VAL_W  = 12;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [11:0] TGT_RST  = 12'h080;
  localparam logic [11:0] EXP_RST  = 12'h100;
  localparam logic [11:0] GAIN_RST = 12'h000;
  localparam logic        ON_RST   = 1'h1;
  localparam logic        AUTO_RST = 1'h0;
  localparam logic        ABS_RST  = 1'h0;

  // ----------------------------------------------------------------
  // Loop constants
  // ----------------------------------------------------------------
  localparam logic [11:0] TGT_MIN   = 12'h032;
  localparam logic [11:0] TGT_MAX   = 12'h0cd;
  localparam logic [2:0]  ONE_FRAMES = 3'h4;
  localparam int          KP_SH     = 2;
  localparam int          KI_SH     = 4;

endpackage

// *** aegc_pi_loop.sv ***
// Purpose: One proportional plus integral loop for a camera setting
// Assumes: step pulses once per frame with mean valid in that cycle
// Notes:   Integrator freezes while the output is clamped
`timescale 1ns/1ns
`default_nettype none
module aegc_pi_loop
  import aegc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Loop control
  input  wire logic        run,
  input  wire logic        step,
  input  wire logic [11:0] target,
  input  wire logic [7:0]  mean,
  input  wire logic [11:0] lo,
  input  wire logic [11:0] hi,
  input  wire logic [11:0] rst_val,
  // Manual load
  input  wire logic        load,
  input  wire logic [11:0] load_val,
  // Setting
  output var  logic [11:0] value_r
);

  logic        [11:0] value_nxt;
  logic signed [15:0] integ_r;
  logic signed [15:0] integ_nxt;
  logic signed [12:0] err;
  logic signed [17:0] sum;
  logic               clamped;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    value_nxt = value_r;
    integ_nxt = integ_r;
    clamped   = 1'b0;
    // Positive error means too dark, so the setting must rise [R3]
    err = $signed({1'b0, target}) - $signed({5'h00, mean});
    // Proportional plus integral correction [R4]
    sum = $signed({6'h00, value_r}) + 18'(err >>> KP_SH)
        + 18'(integ_r >>> KI_SH);
    if (load) begin
      value_nxt = load_val;
      integ_nxt = 16'sh0000;
    end else if (run && step) begin
      // One update per frame, bounded by the limits [R1] [R2] [R17]
      if (sum < $signed({6'h00, lo})) begin
        value_nxt = lo;
        clamped   = 1'b1;
      end else if (sum > $signed({6'h00, hi})) begin
        value_nxt = hi;
        clamped   = 1'b1;
      end else begin
        value_nxt = sum[11:0];
      end
      // Freezing avoids windup, which would cause overshoot [R4]
      if (!clamped) begin
        integ_nxt = integ_r + 16'(err);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      value_r <= rst_val;
      integ_r <= 16'sh0000;
    end else begin
      value_r <= value_nxt;
      integ_r <= integ_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_LOOP_BOUND: assert property (@(posedge clk) // [R1] [R2]
    disable iff (!rst_n)
    (run && step && !load && lo <= hi) |=> (value_r >= $past(lo)
      && value_r <= $past(hi)))
    else $error("loop output left its limits");

  AST_LOOP_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // [R17]
    (!load && !(run && step)) |=> $stable(value_r))
    else $error("loop output moved outside a frame step");

  AST_LOOP_DIR: assert property (@(posedge clk) disable iff (!rst_n) // [R3]
    (run && step && !load && integ_r == 16'sh0000 && value_r >= lo
      && value_r < hi && {4'h0, mean} + 12'h008 < target)
    |=> value_r > $past(value_r))
    else $error("dark frame did not raise the setting");

endmodule
`default_nettype wire

// *** aegc_csr_top.sv ***
// Purpose: Register bank and auto loops for exposure time and gain
// Assumes: Register port is synchronous, one access per cycle
// Notes:   Read data returns one cycle after the read strobe
`timescale 1ns/1ns
`default_nettype none
module aegc_csr_top
  import aegc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [31:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output var  logic [31:0] reg_rdata,
  output var  logic        reg_rvalid,
  // Frame statistics
  input  wire logic        frame_done,
  input  wire logic [7:0]  frame_mean,
  // Limits and absolute values
  input  wire logic [11:0] exp_lo,
  input  wire logic [11:0] exp_hi,
  input  wire logic [11:0] gain_lo,
  input  wire logic [11:0] gain_hi,
  input  wire logic [11:0] tgt_abs,
  input  wire logic [11:0] exp_abs,
  input  wire logic [11:0] gain_abs,
  // Settings to the sensor
  output var  logic [11:0] exposure_out,
  output var  logic        exposure_en,
  output var  logic [11:0] gain_out,
  output var  logic        gain_en
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [2:0]  abs_r;
  logic [2:0]  abs_nxt;
  logic [2:0]  on_r;
  logic [2:0]  on_nxt;
  logic [2:0]  auto_r;
  logic [2:0]  auto_nxt;
  logic [2:0]  busy_r;
  logic [2:0]  busy_nxt;
  logic [2:0]  cnt_r [3];
  logic [2:0]  cnt_nxt [3];
  logic [11:0] tgt_val_r;
  logic [11:0] tgt_val_nxt;
  logic [31:0] rdata_nxt;
  logic        rvalid_nxt;
  logic [11:0] exp_nxt;
  logic [11:0] gain_nxt;
  logic        exp_en_nxt;
  logic        gain_en_nxt;

  // ----------------------------------------------------------------
  // Decode and loop wiring
  // ----------------------------------------------------------------
  logic [2:0]  hit;
  logic [2:0]  wr_hit;
  logic [2:0]  val_ok;
  logic [2:0]  one_ok;
  logic [11:0] tgt_src;
  logic [11:0] tgt_eff;
  logic [11:0] exp_val;
  logic [11:0] gain_val;
  logic        exp_run;
  logic        gain_run;

  assign hit[0] = (reg_addr == ADDR_TGT);
  assign hit[1] = (reg_addr == ADDR_EXP);
  assign hit[2] = (reg_addr == ADDR_GAIN);
  assign wr_hit = reg_wr ? hit : 3'h0;

  always_comb begin
    for (int f = 0; f < 3; f++) begin
      // Value writes count only in manual with the feature on [R12]
      val_ok[f] = wr_hit[f] && on_r[f] && !auto_r[f];
      // One-shot ignored in auto mode [R8]
      one_ok[f] = wr_hit[f] && reg_wdata[B_ONE] && !auto_r[f]
                  && !busy_r[f];
    end
  end

  // Absolute source replaces the value field when selected [R6]
  assign tgt_src = abs_r[0] ? tgt_abs : tgt_val_r;

  // Target held inside the grey level window [R14]
  assign tgt_eff = (tgt_src < TGT_MIN) ? TGT_MIN :
                   (tgt_src > TGT_MAX) ? TGT_MAX : tgt_src;

  // Loops run in auto or during a one-shot, only while on [R1] [R2] [R15]
  assign exp_run  = on_r[1] && (auto_r[1] || busy_r[1]);
  assign gain_run = on_r[2] && (auto_r[2] || busy_r[2]);

  aegc_pi_loop u_exp_loop (
    .clk      (clk),
    .rst_n    (rst_n),
    .run      (exp_run),
    .step     (frame_done),
    .target   (tgt_eff),
    .mean     (frame_mean),
    .lo       (exp_lo),
    .hi       (exp_hi),
    .rst_val  (EXP_RST),
    .load     (val_ok[1]),
    .load_val (reg_wdata[VAL_W-1:0]),
    .value_r  (exp_val)
  );

  aegc_pi_loop u_gain_loop (
    .clk      (clk),
    .rst_n    (rst_n),
    .run      (gain_run),
    .step     (frame_done),
    .target   (tgt_eff),
    .mean     (frame_mean),
    .lo       (gain_lo),
    .hi       (gain_hi),
    .rst_val  (GAIN_RST),
    .load     (val_ok[2]),
    .load_val (reg_wdata[VAL_W-1:0]),
    .value_r  (gain_val)
  );

  // ----------------------------------------------------------------
  // Control bits and one-shots
  // ----------------------------------------------------------------
  always_comb begin
    abs_nxt     = abs_r;
    on_nxt      = on_r;
    auto_nxt    = auto_r;
    busy_nxt    = busy_r;
    tgt_val_nxt = tgt_val_r;
    for (int f = 0; f < 3; f++) begin
      cnt_nxt[f] = cnt_r[f];
      if (wr_hit[f]) begin
        abs_nxt[f]  = reg_wdata[B_ABS];  // [R6]
        on_nxt[f]   = reg_wdata[B_ON];   // [R10]
        auto_nxt[f] = reg_wdata[B_AUTO]; // [R11]
      end
      // Busy clears itself after a fixed number of frames [R7] [R9]
      if (busy_r[f] && frame_done) begin
        if (cnt_r[f] == ONE_FRAMES - 3'h1) begin
          busy_nxt[f] = 1'b0;
          cnt_nxt[f]  = 3'h0;
        end else begin
          cnt_nxt[f] = cnt_r[f] + 3'h1;
        end
      end
      if (one_ok[f]) begin
        busy_nxt[f] = 1'b1; // [R7] [R9]
        cnt_nxt[f]  = 3'h0;
      end
    end
    if (val_ok[0]) begin
      tgt_val_nxt = reg_wdata[VAL_W-1:0]; // [R12]
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      abs_r     <= {3{ABS_RST}};
      on_r      <= {3{ON_RST}};
      auto_r    <= {3{AUTO_RST}};
      busy_r    <= 3'h0;
      tgt_val_r <= TGT_RST;
      for (int f = 0; f < 3; f++) begin
        cnt_r[f] <= 3'h0;
      end
    end else begin
      abs_r     <= abs_nxt;
      on_r      <= on_nxt;
      auto_r    <= auto_nxt;
      busy_r    <= busy_nxt;
      tgt_val_r <= tgt_val_nxt;
      for (int f = 0; f < 3; f++) begin
        cnt_r[f] <= cnt_nxt[f];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and outputs
  // ----------------------------------------------------------------
  function automatic logic [31:0] quad(input logic a, input logic b,
                                       input logic o, input logic m,
                                       input logic [11:0] v);
    // Presence fixed at 1, reserved bits zero [R5] [R16]
    quad = {1'b1, a, 3'h0, b, o, m, 12'h000, v};
  endfunction

  always_comb begin
    rdata_nxt  = 32'h0000_0000;
    rvalid_nxt = reg_rd;
    if (reg_rd) begin
      unique case (1'b1)
        hit[0]:  rdata_nxt = quad(abs_r[0], busy_r[0], on_r[0],
                                  auto_r[0], tgt_val_r);
        hit[1]:  rdata_nxt = quad(abs_r[1], busy_r[1], on_r[1],
                                  auto_r[1], exp_val);
        hit[2]:  rdata_nxt = quad(abs_r[2], busy_r[2], on_r[2],
                                  auto_r[2], gain_val);
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    // Absolute input overrides the loop value [R6]
    exp_nxt     = abs_r[1] ? exp_abs : exp_val;
    gain_nxt    = abs_r[2] ? gain_abs : gain_val;
    exp_en_nxt  = on_r[1]; // [R10]
    gain_en_nxt = on_r[2]; // [R10]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata    <= 32'h0000_0000;
      reg_rvalid   <= 1'b0;
      exposure_out <= EXP_RST;
      gain_out     <= GAIN_RST;
      exposure_en  <= ON_RST;
      gain_en      <= ON_RST;
    end else begin
      reg_rdata    <= rdata_nxt;
      reg_rvalid   <= rvalid_nxt;
      exposure_out <= exp_nxt;
      gain_out     <= gain_nxt;
      exposure_en  <= exp_en_nxt;
      gain_en      <= gain_en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_PRESENCE: assert property (@(posedge clk) disable iff (!rst_n) // [R5]
    (reg_rd && |hit) |=> (reg_rvalid && reg_rdata[B_PRES]))
    else $error("presence bit not set on read");

  AST_RESERVED: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
    reg_rvalid |-> (reg_rdata[29:27] == 3'h0 && reg_rdata[23:12] == 12'h000))
    else $error("reserved bits read nonzero");

  AST_ONE_IGNORED: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
    (wr_hit[1] && reg_wdata[B_ONE] && auto_r[1] && !busy_r[1])
    |=> !busy_r[1])
    else $error("one-shot started in auto mode");

  AST_ONE_START: assert property (@(posedge clk) // [R9]
    disable iff (!rst_n)
    (reg_wr && hit[2] && reg_wdata[B_ONE] && !auto_r[2] && !busy_r[2])
    |=> busy_r[2])
    else $error("gain one-shot did not start");

  AST_BUSY_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // [R9]
    (busy_r[0] && !frame_done) |=> busy_r[0])
    else $error("target one-shot cleared without a frame");

  AST_ONE_CLEAR: assert property (@(posedge clk) disable iff (!rst_n) // [R7]
    (busy_r[1] && frame_done && cnt_r[1] == ONE_FRAMES - 3'h1)
    |=> !busy_r[1])
    else $error("exposure one-shot did not clear");

  AST_DISCARD: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    (wr_hit[0] && (auto_r[0] || !on_r[0])) |=> $stable(tgt_val_r))
    else $error("value write accepted in auto or off");

  AST_MODE_WR: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    wr_hit[2] |=> auto_r[2] == $past(reg_wdata[B_AUTO]))
    else $error("mode bit not stored on write");

  AST_MODE_RB: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
    (reg_rd && hit[2]) |=> reg_rdata[B_AUTO] == $past(auto_r[2]))
    else $error("mode bit not read back");

  AST_TGT_RANGE: assert property (@(posedge clk) disable iff (!rst_n) // [R14]
    tgt_eff >= TGT_MIN && tgt_eff <= TGT_MAX)
    else $error("effective target outside window");

  AST_GAIN_QUIET: assert property (@(posedge clk) disable iff (!rst_n) // [R15]
    (!gain_run && !val_ok[2]) |=> $stable(gain_val))
    else $error("gain moved without auto gain");

  AST_ABS_SEL: assert property (@(posedge clk) disable iff (!rst_n) // [R6]
    abs_r[1] |=> exposure_out == $past(exp_abs))
    else $error("absolute exposure not applied");

  AST_EN_OUT: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
    1'b1 |=> (exposure_en == $past(on_r[1]) && gain_en == $past(on_r[2])))
    else $error("enable outputs do not follow the on bits");

  AST_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n) // [R16]
    (reg_rd && !(|hit)) |=> (reg_rvalid && reg_rdata == 32'h0000_0000))
    else $error("unmapped read returned nonzero data");

  AST_EXP_DROP: assert property (@(posedge clk) disable iff (!rst_n) // [R12]
    (wr_hit[1] && (auto_r[1] || !on_r[1]) && !frame_done)
    |=> $stable(exp_val))
    else $error("exposure value write accepted in auto or off");

endmodule
`default_nettype wire

// *** aegc_host_model.sv ***
// Purpose: Host software model that reaches the register bank
// Assumes: One access at a time, strobes one cycle wide
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module aegc_host_model (
  // Clock
  input  wire logic        clk,
  // Register port
  output var  logic [31:0] reg_addr,
  output var  logic        reg_wr,
  output var  logic        reg_rd,
  output var  logic [31:0] reg_wdata,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  initial begin
    reg_addr  = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 32'h0000_0000;
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    // Stale bus contents must not look like a valid request
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] q,
                    output logic ok);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    ok = reg_rvalid;
    // Whole word handed on; caller masks a value field it cannot trust
    q  = reg_rdata;
  endtask
endmodule
`default_nettype wire

// *** aegc_csr_control_tb_top.sv ***
// Purpose: Self-checking bench for the exposure and gain register bank
// Assumes: Read answer one cycle after the strobe, outputs two after a write
// Notes:   Loop values are checked by direction and clamp, not exact sums
`timescale 1ns/1ns
`default_nettype none
module auto_exposure_gain_csr_control_tb_top
  import aegc_pkg::*;
;
  typedef struct {
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] q;
    logic [11:0] eo;
    logic        en;
  } aegc_row_s;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] reg_addr, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, reg_rvalid, exposure_en, gain_en;
  logic        frame_done = 1'b0;
  logic [7:0]  frame_mean = 8'h00;
  logic [11:0] exp_lo = 12'h000, exp_hi = 12'hfff;
  logic [11:0] gain_lo = 12'h000, gain_hi = 12'hfff;
  logic [11:0] tgt_abs = 12'h080, exp_abs = 12'h0ab, gain_abs = 12'h0cd;
  logic [11:0] exposure_out, gain_out;
  int          err_total = 0;
  int          compares = 0;
  aegc_row_s   rows [11];

  always #4 clk = ~clk;

  aegc_csr_top aegc_csr_top_i (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .frame_done(frame_done),
    .frame_mean(frame_mean), .exp_lo(exp_lo), .exp_hi(exp_hi),
    .gain_lo(gain_lo), .gain_hi(gain_hi), .tgt_abs(tgt_abs),
    .exp_abs(exp_abs), .gain_abs(gain_abs), .exposure_out(exposure_out),
    .exposure_en(exposure_en), .gain_out(gain_out), .gain_en(gain_en));

  aegc_host_model aegc_host_model_i (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  task automatic chk_word(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_set(string n, logic [11:0] e, logic [11:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(string n, logic e, logic g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Write, then let the setting reach the outputs two edges later
  task automatic wr2(logic [31:0] a, logic [31:0] d);
    aegc_host_model_i.wr(a, d);
    repeat (2) @(posedge clk);
  endtask

  task automatic rchk(logic [31:0] a, logic [31:0] e, logic [31:0] m);
    logic [31:0] q;
    logic        ok;
    aegc_host_model_i.rd(a, q, ok);
    chk_bit("rvalid", 1'b1, ok);
    chk_word("rdata", e & m, q & m);
  endtask

  task automatic frame(logic [7:0] m);
    @(posedge clk);
    frame_done <= 1'b1;
    frame_mean <= m;
    @(posedge clk);
    frame_done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic reset_chk;
    // Look after the edge so the outputs have settled
    #1;
    chk_set("exp_rst", EXP_RST, exposure_out);
    chk_set("gain_rst", GAIN_RST, gain_out);
    chk_bit("en_rst", 1'b1, exposure_en & gain_en);
    rchk(ADDR_TGT, 32'h8200_0080, '1);
    rchk(ADDR_EXP, 32'h8200_0100, '1);
    rchk(ADDR_GAIN, 32'h8200_0000, '1);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    stop_test();
  end

  initial begin
    logic [31:0] a;
    rows = '{
      '{ADDR_EXP, 32'h0200_0123, 32'h8200_0123, 12'h123, 1'b1},
      '{ADDR_EXP, 32'h3aff_f456, 32'h8200_0456, 12'h456, 1'b1},
      '{ADDR_EXP, 32'h0000_0456, 32'h8000_0456, 12'h456, 1'b0},
      '{ADDR_EXP, 32'h0000_0321, 32'h8000_0456, 12'h456, 1'b0},
      '{ADDR_EXP, 32'h4200_0456, 32'hc200_0456, 12'h0ab, 1'b1},
      '{ADDR_EXP, 32'h0300_0456, 32'h8300_0456, 12'h456, 1'b1},
      '{ADDR_EXP, 32'h0300_0111, 32'h8300_0456, 12'h456, 1'b1},
      '{ADDR_EXP, 32'h0700_0456, 32'h8300_0456, 12'h456, 1'b1},
      '{ADDR_EXP, 32'h0200_0456, 32'h8200_0456, 12'h456, 1'b1},
      '{ADDR_GAIN, 32'h0200_0055, 32'h8200_0055, 12'h456, 1'b1},
      '{32'hf0f0_0808, 32'h0200_0077, 32'h0000_0000, 12'h456, 1'b1}};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reset_chk();
    $display("test reset done");
    foreach (rows[i]) begin
      wr2(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].q, '1);
      chk_set("exposure_out", rows[i].eo, exposure_out);
      chk_bit("exposure_en", rows[i].en, exposure_en);
    end
    $display("test register rows done");
    // Target clamped at both ends: a mean at the clamp gives no error
    wr2(ADDR_EXP, 32'h0200_0200);
    wr2(ADDR_TGT, 32'h0200_0010);
    wr2(ADDR_EXP, 32'h0300_0200);
    frame(8'h32);
    chk_set("tgt_low", 12'h200, exposure_out);
    wr2(ADDR_TGT, 32'h0200_00f0);
    frame(8'hcd);
    chk_set("tgt_high", 12'h200, exposure_out);
    frame(8'h40);
    chk_bit("exp_up", 1'b1, exposure_out > 12'h200);
    wr2(ADDR_EXP, 32'h0200_0200);
    wr2(ADDR_TGT, 32'h0200_0032);
    wr2(ADDR_EXP, 32'h0300_0200);
    frame(8'h80);
    chk_bit("exp_down", 1'b1, exposure_out < 12'h200);
    $display("test target done");
    // Upper limit holds the loop however dark the frames are
    wr2(ADDR_TGT, 32'h0200_00cd);
    exp_hi <= 12'h210;
    repeat (6) frame(8'h00);
    chk_set("exp_clamp", 12'h210, exposure_out);
    exp_hi <= 12'hfff;
    wr2(ADDR_GAIN, 32'h0200_0100);
    frame(8'h20);
    chk_set("gain_manual", 12'h100, gain_out);
    wr2(ADDR_GAIN, 32'h0300_0100);
    frame(8'h20);
    chk_bit("gain_up", 1'b1, gain_out > 12'h100);
    $display("test loops done");
    // One-shot busy for exactly four frames on every register
    for (int k = 0; k < 3; k++) begin
      a = (k == 0) ? ADDR_TGT : (k == 1) ? ADDR_EXP : ADDR_GAIN;
      wr2(a, 32'h0200_0080);
      wr2(a, 32'h0600_0080);
      rchk(a, 32'h8600_0000, 32'hff00_0000);
      repeat (3) frame(8'h80);
      rchk(a, 32'h8600_0000, 32'hff00_0000);
      frame(8'h80);
      rchk(a, 32'h8200_0000, 32'hff00_0000);
    end
    $display("test one-shot done");
    // Absolute sources and the off state
    wr2(ADDR_GAIN, 32'h4200_0000);
    chk_set("gain_abs", 12'h0cd, gain_out);
    wr2(ADDR_GAIN, 32'h0000_0000);
    chk_bit("gain_en", 1'b0, gain_en);
    wr2(ADDR_GAIN, 32'h0000_0077);
    rchk(ADDR_GAIN, 32'h8000_0000, '1);
    chk_set("gain_off", 12'h000, gain_out);
    wr2(ADDR_EXP, 32'h0300_0200);
    wr2(ADDR_TGT, 32'h4200_0032);
    frame(8'h80);
    chk_set("tgt_abs", 12'h200, exposure_out);
    $display("test absolute and off done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reset_chk();
    $display("test second reset done");
    stop_test();
  end
endmodule
`default_nettype wire
